// ==== hw/apc_setup_ctrl.sv ====
// Audio processor setup control: registers, frame-paced coefficient
// transfer, output enables, tone level decode and power-down wake.
// Assumes an AXI4-Lite master on aclk and asynchronous pin inputs.
//
// Contract
// - Sidetone resets to 18 dB attenuation
// - Both disabled: earpiece, reference, loudspeaker high-impedance
// - Processor enabled: unselected output high-impedance
// - Frame-bit-seven wake needs interrupt and pin enabled
// - Timing-request wake needs interrupt and pin enabled
// - Coefficients move to internal buffers once per frame
// - Zero dB tone yields +3 dBm0
// - Tone gain decodes 2 dB steps
// - Tone gain accepts codes 33, 23, 13
`timescale 1ns/1ps
`default_nettype none
module apc_setup_ctrl #(
  parameter int unsigned FRAME_CYCLES = apc_pkg::FRAME_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_sync_pin,
  input wire logic frame_bit_seven_pin,
  input wire logic timing_request_pin,
  output apc_pkg::apc_coef_t coef_active,
  output apc_pkg::apc_oe_t out_enable,
  output logic ap_enable,
  output logic ringer_enable,
  output logic autozero_enable,
  output logic sidetone_enable,
  output logic power_down,
  output logic signed [5:0] tone_level_dbm0,
  output logic irq
);
  // Register state
  logic [6:0] ctrl_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_stat_next;
  logic [3:0] irq_mask_reg;
  apc_pkg::apc_coef_t shadow_reg;
  apc_pkg::apc_coef_t active_reg;
  apc_pkg::apc_oe_t oe_reg;
  logic pd_reg;
  logic irq_reg;
  logic signed [5:0] tone_level_reg;
  logic tone_ok_reg;

  // Bus state
  logic awready_reg;
  logic wready_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [5:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Frame timing
  logic [apc_pkg::FRAME_CNT_W-1:0] frame_cnt_reg;
  logic frame_tick_reg;

  // Pin inputs
  logic [2:0] pins_sync;
  logic [2:0] pins_prev_reg;
  logic sync_level;
  logic f7_rise;
  logic treq_rise;
  logic sync_rise;
  logic wake_f7;
  logic wake_treq;

  logic wr_fire;
  logic rd_fire;
  logic [31:0] wmask;
  logic [31:0] wr_old;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic [4:0] tone_atten;
  logic tone_valid;

  apc_sync2 #(.W(3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({timing_request_pin, frame_bit_seven_pin, line_sync_pin}),
    .sync_out(pins_sync)
  );

  apc_tone_decode u_tone (
    .code(active_reg.tone),
    .atten_db(tone_atten),
    .valid(tone_valid)
  );

  // Edge detection on synchronised pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_prev_reg <= 3'h0;
    end else begin
      pins_prev_reg <= pins_sync;
    end
  end

  assign sync_level = pins_sync[0];
  assign sync_rise = pins_sync[0] & ~pins_prev_reg[0];
  assign f7_rise = pins_sync[1] & ~pins_prev_reg[1];
  assign treq_rise = pins_sync[2] & ~pins_prev_reg[2];

  // Wake needs both the event interrupt and the pin enabled
  assign wake_f7 = pd_reg & f7_rise & irq_mask_reg[apc_pkg::IRQ_F7]
    & ctrl_reg[apc_pkg::CTRL_IRQ_PIN_EN];
  assign wake_treq = pd_reg & treq_rise & irq_mask_reg[apc_pkg::IRQ_TREQ]
    & ctrl_reg[apc_pkg::CTRL_IRQ_PIN_EN];

  // Byte-lane mask
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wmask[8*i +: 8] = {8{wstrb_reg[i]}};
  end

  function automatic logic [31:0] reg_value(input logic [5:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == apc_pkg::CTRL_ADDR) begin
      v[6:0] = ctrl_reg;
    end else if (a == apc_pkg::STATUS_ADDR) begin
      v[apc_pkg::ST_PD] = pd_reg;
      v[apc_pkg::ST_SYNC] = sync_level;
      v[apc_pkg::ST_EAR_OE] = oe_reg.ear_oe;
      v[apc_pkg::ST_LS_OE] = oe_reg.ls_oe;
      v[apc_pkg::ST_ANALOG_REFERENCE_OUTPUT_OE] = oe_reg.analog_reference_output_oe;
      v[apc_pkg::ST_TONE_OK] = tone_ok_reg;
    end else if (a == apc_pkg::IRQ_STAT_ADDR) begin
      v[3:0] = irq_stat_reg;
    end else if (a == apc_pkg::IRQ_MASK_ADDR) begin
      v[3:0] = irq_mask_reg;
    end else if (a == apc_pkg::SIDETONE_ADDR) begin
      v[7:0] = shadow_reg.sidetone;
    end else if (a == apc_pkg::TONE_ADDR) begin
      v[7:0] = shadow_reg.tone;
    end else if (a == apc_pkg::TX_GAIN_ADDR) begin
      v[15:0] = shadow_reg.tx_gain;
    end else if (a == apc_pkg::RX_GAIN_ADDR) begin
      v[15:0] = shadow_reg.rx_gain;
    end else if (a == apc_pkg::EAR_GAIN_ADDR) begin
      v[15:0] = shadow_reg.ear_gain;
    end else if (a == apc_pkg::RINGER_ADDR) begin
      v[7:0] = shadow_reg.ringer_freq;
    end
    return v;
  endfunction

  function automatic logic addr_mapped(input logic [5:0] a);
    return (a[1:0] == 2'h0) && (a <= apc_pkg::RINGER_ADDR);
  endfunction

  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign rd_fire = s_axi_arvalid & arready_reg;
  // A process, so that register changes re-evaluate the read-back
  always_comb begin
    wr_old = reg_value(awaddr_reg);
    rd_word = reg_value(s_axi_araddr);
  end
  assign wr_word = (wr_old & ~wmask) | (wdata_reg & wmask);

  // Write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 6'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= apc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= addr_mapped(awaddr_reg) ? apc_pkg::RESP_OKAY
        : apc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= apc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= addr_mapped(s_axi_araddr) ? apc_pkg::RESP_OKAY
        : apc_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= apc_pkg::CTRL_RESET;
      irq_mask_reg <= apc_pkg::IRQ_MASK_RESET;
      shadow_reg <= apc_pkg::COEF_RESET;
    end else if (wr_fire) begin
      if (awaddr_reg == apc_pkg::CTRL_ADDR) begin
        ctrl_reg <= wr_word[6:0];
        ctrl_reg[apc_pkg::CTRL_PD_REQ] <= 1'b0;
      end else if (awaddr_reg == apc_pkg::IRQ_MASK_ADDR) begin
        irq_mask_reg <= wr_word[3:0];
      end else if (awaddr_reg == apc_pkg::SIDETONE_ADDR) begin
        shadow_reg.sidetone <= wr_word[7:0];
      end else if (awaddr_reg == apc_pkg::TONE_ADDR) begin
        shadow_reg.tone <= wr_word[7:0];
      end else if (awaddr_reg == apc_pkg::TX_GAIN_ADDR) begin
        shadow_reg.tx_gain <= wr_word[15:0];
      end else if (awaddr_reg == apc_pkg::RX_GAIN_ADDR) begin
        shadow_reg.rx_gain <= wr_word[15:0];
      end else if (awaddr_reg == apc_pkg::EAR_GAIN_ADDR) begin
        shadow_reg.ear_gain <= wr_word[15:0];
      end else if (awaddr_reg == apc_pkg::RINGER_ADDR) begin
        shadow_reg.ringer_freq <= wr_word[7:0];
      end
    end
  end

  // Frame timebase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt_reg <= '0;
      frame_tick_reg <= 1'b0;
    end else if (frame_cnt_reg ==
        apc_pkg::FRAME_CNT_W'(FRAME_CYCLES - 1)) begin
      frame_cnt_reg <= '0;
      frame_tick_reg <= 1'b1;
    end else begin
      frame_cnt_reg <= frame_cnt_reg + 1'b1;
      frame_tick_reg <= 1'b0;
    end
  end

  // Internal buffers follow the shadow once per frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= apc_pkg::COEF_RESET;
    end else if (frame_tick_reg) begin
      active_reg <= shadow_reg;
    end
  end

  // Tone level relative to the overload reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_level_reg <= apc_pkg::TONE_REF_DBM0;
      tone_ok_reg <= 1'b1;
    end else begin
      tone_level_reg <= apc_pkg::TONE_REF_DBM0
        - $signed({1'b0, tone_atten});
      tone_ok_reg <= tone_valid;
    end
  end

  // Output drive enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_reg <= '0;
    end else if (!ctrl_reg[apc_pkg::CTRL_AP_EN]
        && !ctrl_reg[apc_pkg::CTRL_RINGER_EN]) begin
      oe_reg <= '0;
    end else begin
      oe_reg.analog_reference_output_oe <= 1'b1;
      oe_reg.ls_oe <= ctrl_reg[apc_pkg::CTRL_SEL_LS];
      oe_reg.ear_oe <= ~ctrl_reg[apc_pkg::CTRL_SEL_LS];
    end
  end

  // Power-down: entered by request, left on an enabled wake event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_reg <= 1'b0;
    end else if (wake_f7 || wake_treq) begin
      pd_reg <= 1'b0;
    end else if (wr_fire && awaddr_reg == apc_pkg::CTRL_ADDR
        && wr_word[apc_pkg::CTRL_PD_REQ]) begin
      pd_reg <= 1'b1;
    end
  end

  // Sticky interrupt status; a new event wins over the read clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (rd_fire && s_axi_araddr == apc_pkg::IRQ_STAT_ADDR) begin
      irq_stat_next = 4'h0;
    end
    irq_stat_next[apc_pkg::IRQ_F7] = irq_stat_next[apc_pkg::IRQ_F7] | f7_rise;
    irq_stat_next[apc_pkg::IRQ_TREQ] =
      irq_stat_next[apc_pkg::IRQ_TREQ] | treq_rise;
    irq_stat_next[apc_pkg::IRQ_SYNC] =
      irq_stat_next[apc_pkg::IRQ_SYNC] | sync_rise;
    irq_stat_next[apc_pkg::IRQ_WAKE] =
      irq_stat_next[apc_pkg::IRQ_WAKE] | wake_f7 | wake_treq;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= ctrl_reg[apc_pkg::CTRL_IRQ_PIN_EN]
        & (|(irq_stat_next & irq_mask_reg));
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign coef_active = active_reg;
  assign out_enable = oe_reg;
  assign ap_enable = ctrl_reg[apc_pkg::CTRL_AP_EN];
  assign ringer_enable = ctrl_reg[apc_pkg::CTRL_RINGER_EN];
  assign autozero_enable = ctrl_reg[apc_pkg::CTRL_AUTOZERO];
  assign sidetone_enable = ctrl_reg[apc_pkg::CTRL_SIDETONE_EN];
  assign power_down = pd_reg;
  assign tone_level_dbm0 = tone_level_reg;
  assign irq = irq_reg;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_both_off;
    !ctrl_reg[apc_pkg::CTRL_AP_EN] && !ctrl_reg[apc_pkg::CTRL_RINGER_EN];
  endsequence

  sequence s_f7_wake_armed;
    pd_reg && f7_rise && irq_mask_reg[apc_pkg::IRQ_F7]
      && ctrl_reg[apc_pkg::CTRL_IRQ_PIN_EN];
  endsequence

  a_sidetone_default: assert property (
    $rose(aresetn) |-> active_reg.sidetone == 8'h12
      && shadow_reg.sidetone == 8'h12)
    else $error("sidetone not at default after reset");

  a_outputs_hiz: assert property (
    s_both_off |=> !oe_reg.ear_oe && !oe_reg.ls_oe && !oe_reg.analog_reference_output_oe)
    else $error("outputs driven while both paths disabled");

  a_unselected_hiz: assert property (
    ctrl_reg[apc_pkg::CTRL_AP_EN] |=>
      (oe_reg.ls_oe != oe_reg.ear_oe) && oe_reg.analog_reference_output_oe)
    else $error("unselected output not high impedance");

  a_frame_update: assert property (
    !frame_tick_reg |=> $stable(active_reg))
    else $error("coefficients moved outside a frame boundary");

  a_frame_copy: assert property (
    frame_tick_reg |=> active_reg == $past(shadow_reg))
    else $error("frame boundary did not copy coefficients");

  a_tone_zero: assert property (
    active_reg.tone == 8'h10 |=> tone_level_reg == 6'sh03)
    else $error("zero dB tone not at +3 dBm0");

  a_tone_steps: assert property (
    active_reg.tone == 8'h37 |=> tone_level_reg == -6'sd15 && tone_ok_reg)
    else $error("code 37 not -18 dB");

  a_tone_extra: assert property (
    active_reg.tone == 8'h23 |=> tone_level_reg == -6'sd8 && tone_ok_reg)
    else $error("code 23 not -11 dB");

  a_wake_f7: assert property (
    s_f7_wake_armed |=> !pd_reg && irq_stat_reg[apc_pkg::IRQ_WAKE])
    else $error("frame bit seven wake failed");

  a_wake_blocked: assert property (
    pd_reg && !ctrl_reg[apc_pkg::CTRL_IRQ_PIN_EN] && !wr_fire |=> pd_reg)
    else $error("wake without interrupt pin enabled");

  a_bresp_hold: assert property (
    bvalid_reg && !s_axi_bready |=> bvalid_reg && $stable(bresp_reg))
    else $error("write response dropped before taken");
endmodule
`default_nettype wire

// ==== hw/apc_pkg.sv ====
// Package for the audio processor setup control block.
// Assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus.
package apc_pkg;

  // Clock and frame timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned FRAME_NS = 125000;
  localparam int unsigned FRAME_CYCLES_DEF = FRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAME_CNT_W = 15;

  // Register byte addresses
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] CTRL_ADDR = 6'h00;
  localparam logic [5:0] STATUS_ADDR = 6'h04;
  localparam logic [5:0] IRQ_STAT_ADDR = 6'h08;
  localparam logic [5:0] IRQ_MASK_ADDR = 6'h0c;
  localparam logic [5:0] SIDETONE_ADDR = 6'h10;
  localparam logic [5:0] TONE_ADDR = 6'h14;
  localparam logic [5:0] TX_GAIN_ADDR = 6'h18;
  localparam logic [5:0] RX_GAIN_ADDR = 6'h1c;
  localparam logic [5:0] EAR_GAIN_ADDR = 6'h20;
  localparam logic [5:0] RINGER_ADDR = 6'h24;

  // Control register bit positions
  localparam int unsigned CTRL_AP_EN = 0;
  localparam int unsigned CTRL_RINGER_EN = 1;
  localparam int unsigned CTRL_AUTOZERO = 2;
  localparam int unsigned CTRL_SEL_LS = 3;
  localparam int unsigned CTRL_IRQ_PIN_EN = 4;
  localparam int unsigned CTRL_PD_REQ = 5;
  localparam int unsigned CTRL_SIDETONE_EN = 6;
  localparam int unsigned CTRL_W = 7;
  localparam logic [6:0] CTRL_RESET = 7'h40;

  // Status register bit positions
  localparam int unsigned ST_PD = 0;
  localparam int unsigned ST_SYNC = 1;
  localparam int unsigned ST_EAR_OE = 2;
  localparam int unsigned ST_LS_OE = 3;
  localparam int unsigned ST_ANALOG_REFERENCE_OUTPUT_OE = 4;
  localparam int unsigned ST_TONE_OK = 5;

  // Interrupt bits, shared by status and mask
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_F7 = 0;
  localparam int unsigned IRQ_TREQ = 1;
  localparam int unsigned IRQ_SYNC = 2;
  localparam int unsigned IRQ_WAKE = 3;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // Sidetone attenuation in dB; all ones means infinite attenuation
  localparam logic [7:0] SIDETONE_RESET = 8'h12;
  localparam logic [7:0] SIDETONE_MUTE = 8'hff;

  // Tone level reference: a 0 dB tone is +3 dBm0
  localparam logic signed [5:0] TONE_REF_DBM0 = 6'sh03;
  localparam logic [7:0] TONE_RESET = 8'h10;
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [7:0] RINGER_RESET = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [15:0] tx_gain;
    logic [15:0] rx_gain;
    logic [15:0] ear_gain;
    logic [7:0] sidetone;
    logic [7:0] tone;
    logic [7:0] ringer_freq;
  } apc_coef_t;

  localparam apc_coef_t COEF_RESET = '{
    tx_gain: GAIN_RESET,
    rx_gain: GAIN_RESET,
    ear_gain: GAIN_RESET,
    sidetone: SIDETONE_RESET,
    tone: TONE_RESET,
    ringer_freq: RINGER_RESET
  };

  typedef struct packed {
    logic ear_oe;
    logic ls_oe;
    logic analog_reference_output_oe;
  } apc_oe_t;

endpackage

// ==== hw/apc_sync2.sv ====
// Two-flop synchroniser for pin inputs.
// Assumes the inputs are levels that stay put for several clocks.
`timescale 1ns/1ps
`default_nettype none
module apc_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ==== hw/apc_tone_decode.sv ====
// Tone amplitude gain code decoder.
// Assumes a registered code; output is combinational.
`timescale 1ns/1ps
`default_nettype none
module apc_tone_decode (
  input wire logic [7:0] code,
  output logic [4:0] atten_db,
  output logic valid
);
  always_comb begin
    valid = 1'b1;
    case (code)
      8'h37: atten_db = 5'h12;
      8'h33: atten_db = 5'h11;
      8'h32: atten_db = 5'h10;
      8'h31: atten_db = 5'h0e;
      8'h27: atten_db = 5'h0c;
      8'h23: atten_db = 5'h0b;
      8'h22: atten_db = 5'h0a;
      8'h21: atten_db = 5'h08;
      8'h20: atten_db = 5'h06;
      8'h13: atten_db = 5'h05;
      8'h12: atten_db = 5'h04;
      8'h11: atten_db = 5'h02;
      8'h10: atten_db = 5'h00;
      default: begin
        atten_db = 5'h00;
        valid = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== dv/apc_setup_ctrl_tb.sv ====
// Self-checking bench for the audio processor setup control block.
// Assumes the design files and apc_pkg are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module apc_setup_ctrl_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [5:0] s_axi_araddr = 6'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  logic line_sync_pin = 1'b0;
  logic frame_bit_seven_pin = 1'b0;
  logic timing_request_pin = 1'b0;
  apc_pkg::apc_coef_t coef_active;
  apc_pkg::apc_oe_t out_enable;
  logic ap_enable;
  logic ringer_enable;
  logic autozero_enable;
  logic sidetone_enable;
  logic power_down;
  logic signed [5:0] tone_level_dbm0;
  logic irq;
  int num_errors = 0;
  int tests_run = 0;
  int unsigned cycles = 0;
  logic [33:0] exp_q[$];
  logic [7:0] tcode [13] = '{8'h37, 8'h33, 8'h32, 8'h31, 8'h27, 8'h23,
    8'h22, 8'h21, 8'h20, 8'h13, 8'h12, 8'h11, 8'h10};
  logic [4:0] tatt [13] = '{5'h12, 5'h11, 5'h10, 5'h0e, 5'h0c, 5'h0b,
    5'h0a, 5'h08, 5'h06, 5'h05, 5'h04, 5'h02, 5'h00};
  logic [7:0] ctl_v [6] = '{8'h44, 8'h45, 8'h4d, 8'h42, 8'h4a, 8'h40};
  logic [2:0] oe_v [6] = '{3'h0, 3'h5, 3'h3, 3'h5, 3'h3, 3'h0};

  apc_setup_ctrl #(.FRAME_CYCLES(16)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .line_sync_pin(line_sync_pin),
    .frame_bit_seven_pin(frame_bit_seven_pin),
    .timing_request_pin(timing_request_pin),
    .coef_active(coef_active), .out_enable(out_enable),
    .ap_enable(ap_enable), .ringer_enable(ringer_enable),
    .autozero_enable(autozero_enable),
    .sidetone_enable(sidetone_enable), .power_down(power_down),
    .tone_level_dbm0(tone_level_dbm0), .irq(irq)
  );

  always #2.5 aclk = ~aclk;

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check_port(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bus(input logic [33:0] got);
    logic [33:0] e;
    tests_run++;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3ffffffff;
    if (got !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  // Bus answers are matched against the oldest queued note
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check_bus({s_axi_bresp, 32'h0});
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      check_bus({s_axi_rresp, s_axi_rdata});
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    exp_q.push_back({r, 32'h0});
    s_axi_bready <= 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Late response acceptance, so the slave must hold its answer
    repeat ($urandom_range(3, 0)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
  endtask

  // Pin held high long enough to pass the synchroniser
  task automatic pulse(input logic which);
    if (which) timing_request_pin <= 1'b1;
    else frame_bit_seven_pin <= 1'b1;
    tick(4);
    timing_request_pin <= 1'b0;
    frame_bit_seven_pin <= 1'b0;
    tick(6);
  endtask

  initial begin
    logic signed [5:0] e;
    logic [15:0] g;
    logic [7:0] c;
    int i;
    void'($urandom(32'hf0f4));
    tick(16);
    aresetn <= 1'b1;
    tick(1);
    check_port(34'(coef_active.sidetone), 34'h12);
    check_port(34'(sidetone_enable), 34'h1);
    check_port(34'(out_enable), 34'h0);
    check_port(34'(tone_level_dbm0), 34'(6'sh03));
    rd(apc_pkg::CTRL_ADDR, 32'h40, apc_pkg::RESP_OKAY);
    rd(apc_pkg::SIDETONE_ADDR, 32'h12, apc_pkg::RESP_OKAY);
    rd(apc_pkg::IRQ_MASK_ADDR, 32'h0, apc_pkg::RESP_OKAY);
    rd(apc_pkg::TONE_ADDR, 32'h10, apc_pkg::RESP_OKAY);
    rd(6'h28, 32'h0, apc_pkg::RESP_SLVERR);
    rd(6'h02, 32'h0, apc_pkg::RESP_SLVERR);
    wr(6'h28, 32'h1, apc_pkg::RESP_SLVERR);
    wr(apc_pkg::STATUS_ADDR, 32'h3f, apc_pkg::RESP_OKAY);
    for (i = 0; i < 13; i++) begin
      wr(apc_pkg::TONE_ADDR, 32'(tcode[i]), apc_pkg::RESP_OKAY);
      tick(20);
      e = 6'sh03 - $signed({1'b0, tatt[i]});
      check_port(34'(tone_level_dbm0), 34'(e));
    end
    c = 8'h40 + 8'($urandom_range(191, 0));
    wr(apc_pkg::TONE_ADDR, 32'(c), apc_pkg::RESP_OKAY);
    tick(20);
    check_port(34'(tone_level_dbm0), 34'(6'sh03));
    rd(apc_pkg::STATUS_ADDR, 32'h0, apc_pkg::RESP_OKAY);
    wr(apc_pkg::TONE_ADDR, 32'h10, apc_pkg::RESP_OKAY);
    wr(apc_pkg::SIDETONE_ADDR, 32'h20, apc_pkg::RESP_OKAY);
    for (i = 0; i < 40 && coef_active.sidetone !== 8'h20; i++) tick(1);
    wr(apc_pkg::SIDETONE_ADDR, 32'hff, apc_pkg::RESP_OKAY);
    tick(4);
    check_port(34'(coef_active.sidetone), 34'h20);
    tick(13);
    check_port(34'(coef_active.sidetone), 34'hff);
    check_port(34'(sidetone_enable), 34'h1);
    wr(apc_pkg::IRQ_MASK_ADDR, 32'h0, apc_pkg::RESP_OKAY);
    g = 16'($urandom());
    wr(apc_pkg::TX_GAIN_ADDR, 32'(g), apc_pkg::RESP_OKAY);
    rd(apc_pkg::TX_GAIN_ADDR, 32'(g), apc_pkg::RESP_OKAY);
    tick(20);
    check_port(34'(coef_active.tx_gain), 34'(g));
    line_sync_pin <= 1'b1;
    tick(6);
    rd(apc_pkg::STATUS_ADDR, 32'h22, apc_pkg::RESP_OKAY);
    wr(apc_pkg::RINGER_ADDR, 32'h05, apc_pkg::RESP_OKAY);
    for (i = 0; i < 6; i++) begin
      wr(apc_pkg::CTRL_ADDR, 32'(ctl_v[i]), apc_pkg::RESP_OKAY);
      tick(2);
      check_port(34'(out_enable), 34'(oe_v[i]));
      c = {5'h00, autozero_enable, ringer_enable, ap_enable};
      check_port(34'(c), 34'(ctl_v[i] & 8'h07));
    end
    check_port(34'(coef_active.ringer_freq), 34'h05);
    rd(apc_pkg::IRQ_STAT_ADDR, 32'h4, apc_pkg::RESP_OKAY);
    wr(apc_pkg::IRQ_MASK_ADDR, 32'h1, apc_pkg::RESP_OKAY);
    wr(apc_pkg::CTRL_ADDR, 32'h50, apc_pkg::RESP_OKAY);
    pulse(1'b0);
    check_port(34'(irq), 34'h1);
    rd(apc_pkg::IRQ_STAT_ADDR, 32'h1, apc_pkg::RESP_OKAY);
    tick(2);
    check_port(34'(irq), 34'h0);
    wr(apc_pkg::IRQ_MASK_ADDR, 32'h0, apc_pkg::RESP_OKAY);
    pulse(1'b1);
    check_port(34'(irq), 34'h0);
    rd(apc_pkg::IRQ_STAT_ADDR, 32'h2, apc_pkg::RESP_OKAY);
    wr(apc_pkg::IRQ_MASK_ADDR, 32'h1, apc_pkg::RESP_OKAY);
    wr(apc_pkg::CTRL_ADDR, 32'h70, apc_pkg::RESP_OKAY);
    tick(2);
    check_port(34'(power_down), 34'h1);
    pulse(1'b0);
    check_port(34'(power_down), 34'h0);
    rd(apc_pkg::IRQ_STAT_ADDR, 32'h9, apc_pkg::RESP_OKAY);
    wr(apc_pkg::IRQ_MASK_ADDR, 32'h2, apc_pkg::RESP_OKAY);
    wr(apc_pkg::CTRL_ADDR, 32'h60, apc_pkg::RESP_OKAY);
    tick(2);
    pulse(1'b1);
    check_port(34'(power_down), 34'h1);
    wr(apc_pkg::CTRL_ADDR, 32'h70, apc_pkg::RESP_OKAY);
    pulse(1'b1);
    check_port(34'(power_down), 34'h0);
    rd(apc_pkg::IRQ_STAT_ADDR, 32'ha, apc_pkg::RESP_OKAY);
    tick(2);
    test_done();
  end
endmodule
`default_nettype wire
